// [hw/protector_fault_pkg.sv]
// Package for the protector fault status bank.
// Assumes APB with 32-bit data; byte address is four times a register index.
package protector_fault_pkg;

  // APB byte address width
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam int STAT_W = 8;
  localparam int CELLS = 16;

  // Register indexes; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_PARITY_STATUS = 12'h53a;
  localparam logic [IDX_W-1:0] IDX_SELFTEST_STATUS = 12'h53b;
  localparam logic [IDX_W-1:0] IDX_OV_STATUS_HIGH = 12'h53c;
  localparam logic [IDX_W-1:0] IDX_OV_STATUS_LOW = 12'h53d;
  localparam logic [IDX_W-1:0] IDX_FAULT_CLEAR = 12'h550;

  // Values after reset
  localparam logic [STAT_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Parity status fields
  localparam int TEMP_PARITY_BIT = 1;
  localparam int VOLT_PARITY_BIT = 0;

  // Self-test status fields
  localparam int ABORT_BIT = 6;
  localparam int TEMP_PATH_BIT = 5;
  localparam int VOLT_PATH_BIT = 4;
  localparam int UT_COMP_BIT = 3;
  localparam int OT_COMP_BIT = 2;
  localparam int OV_COMP_BIT = 1;
  localparam int UV_COMP_BIT = 0;

  // Byte lanes of the clear register
  localparam int CLR_PARITY_LSB = 0;
  localparam int CLR_SELFTEST_LSB = 8;
  localparam int CLR_OV_LOW_LSB = 16;
  localparam int CLR_OV_HIGH_LSB = 24;

  // APB slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } apb_state_e;

endpackage : protector_fault_pkg

// [hw/protector_fault_status_bank.sv]
// Protector fault status bank: parity, self-test and cell overvoltage flags.
// Assumes an APB master on sys_clk and fault inputs synchronous to sys_clk.
//
// Implementation choice: the APB interface to the registers.

// Contract
// - Either protector's self-test abort sets bit 6; a completed run leaves it 0
// - Temperature path fault sets bit 5, voltage path fault sets bit 4
// - Comparator failures: undertemp bit 3, overtemp 2, overvoltage 1, undervoltage 0
// - Cells 1 to 8 overvoltage at 0x053D, cell 8 in bit 7
// - Cell overvoltage flags come from the comparator, not the converter
module protector_fault_status_bank
  import protector_fault_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tempConfigParityError,
  input wire logic voltConfigParityError,
  input wire logic selftestStart,
  input wire logic voltSelftestAbort,
  input wire logic tempSelftestAbort,
  input wire logic tempPathSelftestError,
  input wire logic voltPathSelftestError,
  input wire logic undertempComparatorError,
  input wire logic overtempComparatorError,
  input wire logic overvoltageComparatorError,
  input wire logic undervoltageComparatorError,
  input wire logic [CELLS-1:0] cellOvCompare,
  output logic faultPresent
);

  apb_state_e state_ff;
  apb_state_e nxt_state;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic faultPresent_ff;
  logic nxt_faultPresent;

  logic [STAT_W-1:0] parityStat;
  logic [STAT_W-1:0] selftestStat;
  logic [STAT_W-1:0] ovHighStat;
  logic [STAT_W-1:0] ovLowStat;
  logic [STAT_W-1:0] paritySet;
  logic [STAT_W-1:0] selftestSet;
  logic [STAT_W-1:0] selftestClr;
  logic [STAT_W-1:0] parityClr;
  logic [STAT_W-1:0] ovHighClr;
  logic [STAT_W-1:0] ovLowClr;
  logic [IDX_W-1:0] regIdx;
  logic aligned;
  logic clearWrite;

  // Decode
  always_comb begin
    regIdx = paddr[ADDR_W-1:2];
    aligned = (paddr[1:0] == 2'b00);
    clearWrite = (state_ff == ST_ANSWER) && psel && penable && pwrite &&
                 aligned && (regIdx == IDX_FAULT_CLEAR);
  end

  // Event sources of the sticky flags
  always_comb begin
    paritySet = '0;
    paritySet[TEMP_PARITY_BIT] = tempConfigParityError;
    paritySet[VOLT_PARITY_BIT] = voltConfigParityError;
    selftestSet = '0;
    selftestSet[ABORT_BIT] = voltSelftestAbort | tempSelftestAbort;
    selftestSet[TEMP_PATH_BIT] = tempPathSelftestError;
    selftestSet[VOLT_PATH_BIT] = voltPathSelftestError;
    selftestSet[UT_COMP_BIT] = undertempComparatorError;
    selftestSet[OT_COMP_BIT] = overtempComparatorError;
    selftestSet[OV_COMP_BIT] = overvoltageComparatorError;
    selftestSet[UV_COMP_BIT] = undervoltageComparatorError;
  end

  // Clears from software; a new self-test run starts from zero
  always_comb begin
    parityClr = clearWrite ? pwdata[CLR_PARITY_LSB +: STAT_W] : '0;
    ovLowClr = clearWrite ? pwdata[CLR_OV_LOW_LSB +: STAT_W] : '0;
    ovHighClr = clearWrite ? pwdata[CLR_OV_HIGH_LSB +: STAT_W] : '0;
    selftestClr = clearWrite ? pwdata[CLR_SELFTEST_LSB +: STAT_W] : '0;
    if (selftestStart) begin
      selftestClr = '1;
    end
  end

  sticky_flags #(.W(STAT_W)) parityFlags (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .setIn(paritySet),
    .clearIn(parityClr),
    .flags(parityStat)
  );

  sticky_flags #(.W(STAT_W)) selftestFlags (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .setIn(selftestSet),
    .clearIn(selftestClr),
    .flags(selftestStat)
  );

  // Cells 9..16 from comparator outputs only
  sticky_flags #(.W(STAT_W)) ovHighFlags (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .setIn(cellOvCompare[CELLS-1:STAT_W]),
    .clearIn(ovHighClr),
    .flags(ovHighStat)
  );

  // Cells 1..8 from comparator outputs only
  sticky_flags #(.W(STAT_W)) ovLowFlags (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .setIn(cellOvCompare[STAT_W-1:0]),
    .clearIn(ovLowClr),
    .flags(ovLowStat)
  );

  // APB slave, one wait state
  always_comb begin
    nxt_state = state_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (psel && penable) begin
          nxt_state = ST_ANSWER;
          nxt_pready = 1'b1;
          nxt_prdata = RDATA_RESET;
          nxt_pslverr = !aligned;
          if (aligned) begin
            case (regIdx)
              IDX_PARITY_STATUS: begin
                nxt_prdata[STAT_W-1:0] = parityStat;
                nxt_pslverr = pwrite;
              end
              IDX_SELFTEST_STATUS: begin
                nxt_prdata[STAT_W-1:0] = selftestStat;
                nxt_pslverr = pwrite;
              end
              IDX_OV_STATUS_HIGH: begin
                nxt_prdata[STAT_W-1:0] = ovHighStat;
                nxt_pslverr = pwrite;
              end
              IDX_OV_STATUS_LOW: begin
                nxt_prdata[STAT_W-1:0] = ovLowStat;
                nxt_pslverr = pwrite;
              end
              IDX_FAULT_CLEAR: begin
                nxt_pslverr = 1'b0;
              end
              default: begin
                nxt_pslverr = 1'b1;
              end
            endcase
          end
        end
      end
      ST_ANSWER: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_faultPresent = |{parityStat, selftestStat, ovHighStat, ovLowStat};
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      prdata_ff <= RDATA_RESET;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      faultPresent_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      faultPresent_ff <= nxt_faultPresent;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign faultPresent = faultPresent_ff;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_abort_sets_flag: assert property (
    (voltSelftestAbort || tempSelftestAbort) |=> selftestStat[ABORT_BIT])
    else $error("self-test abort flag not set");

  a_start_clears_abort: assert property (
    (selftestStart && !voltSelftestAbort && !tempSelftestAbort)
    |=> !selftestStat[ABORT_BIT])
    else $error("abort flag survived a new run");

  a_path_faults: assert property (
    (tempPathSelftestError || voltPathSelftestError)
    |=> (selftestStat[TEMP_PATH_BIT] || !$past(tempPathSelftestError)) &&
        (selftestStat[VOLT_PATH_BIT] || !$past(voltPathSelftestError)))
    else $error("path fault flags misplaced");

  a_comp_faults: assert property (
    {undertempComparatorError, overtempComparatorError,
     overvoltageComparatorError, undervoltageComparatorError} != 4'h0
    |=> (selftestStat[UT_COMP_BIT:UV_COMP_BIT] &
         $past({undertempComparatorError, overtempComparatorError,
                overvoltageComparatorError, undervoltageComparatorError}))
        == $past({undertempComparatorError, overtempComparatorError,
                  overvoltageComparatorError,
                  undervoltageComparatorError}))
    else $error("comparator failure flags misplaced");

  a_ov_high_map: assert property (
    cellOvCompare[CELLS-1] |=> ovHighStat[STAT_W-1] ##1
    (ovHighStat[STAT_W-1] || $past(clearWrite)))
    else $error("cell 16 flag not in top bit");

  a_ov_low_map: assert property (
    cellOvCompare[0] |=> ovLowStat[0])
    else $error("cell 1 flag not in bit 0");

  a_ov_from_comp: assert property (
    $rose(ovLowStat[STAT_W-1]) |-> $past(cellOvCompare[STAT_W-1]))
    else $error("cell 8 flag rose without comparator");

  a_parity_bits: assert property (
    tempConfigParityError ##0 !voltConfigParityError ##0
    (parityStat[VOLT_PARITY_BIT] == 1'b0)
    |=> parityStat[TEMP_PARITY_BIT] && !parityStat[VOLT_PARITY_BIT])
    else $error("temperature parity flag misplaced");

  a_answer_timing: assert property (
    (psel && penable && state_ff == ST_IDLE) |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

  c_abort_read: cover property (selftestStat[ABORT_BIT] ##[1:20] pready);
  c_clear_write: cover property (clearWrite);
  c_ov_both: cover property (ovHighStat[0] && ovLowStat[STAT_W-1]);
  c_bad_access: cover property (pready && pslverr);

endmodule : protector_fault_status_bank

// [hw/sticky_flags.sv]
// Sticky flag register: hardware sets, a clear vector clears.
// Assumes set and clear are synchronous to sys_clk; set wins over clear.
module sticky_flags
  import protector_fault_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] setIn,
  input wire logic [W-1:0] clearIn,
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_ff;
  logic [W-1:0] nxt_flags;

  // Set wins over clear in the same cycle
  always_comb begin
    nxt_flags = (flags_ff & ~clearIn) | setIn;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule : sticky_flags

// [testbench/tb_top.sv]
// Self-checking bench for the protector fault status bank.
// Assumes the package and the bank module are compiled before this file.
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top
  import protector_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [ADDR_W-1:0] A_PAR = {IDX_PARITY_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] A_ST = {IDX_SELFTEST_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] A_OVH = {IDX_OV_STATUS_HIGH, 2'b00};
  localparam logic [ADDR_W-1:0] A_OVL = {IDX_OV_STATUS_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] A_CLR = {IDX_FAULT_CLEAR, 2'b00};

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic faultPresent;
  logic stStart = 1'b0;
  logic [9:0] flt = '0;
  logic [15:0] cellOv = '0;
  logic [9:0] v;
  logic [15:0] ov;
  logic [ADDR_W-1:0] regs [4] = '{A_PAR, A_ST, A_OVH, A_OVL};
  int seed = 32'h366f;
  int miscompares = 0;
  int n_checks = 0;

  always #5 sys_clk = ~sys_clk;

  protector_fault_status_bank DUT (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .tempConfigParityError(flt[1]),
    .voltConfigParityError(flt[0]),
    .selftestStart(stStart),
    .voltSelftestAbort(flt[8]),
    .tempSelftestAbort(flt[9]),
    .tempPathSelftestError(flt[7]),
    .voltPathSelftestError(flt[6]),
    .undertempComparatorError(flt[5]),
    .overtempComparatorError(flt[4]),
    .overvoltageComparatorError(flt[3]),
    .undervoltageComparatorError(flt[2]),
    .cellOvCompare(cellOv),
    .faultPresent(faultPresent)
  );

  // Expected register contents from the fault vector
  function automatic logic [7:0] exp_par(input logic [9:0] f);
    return {6'h00, f[1:0]};
  endfunction : exp_par

  function automatic logic [7:0] exp_st(input logic [9:0] f);
    return {1'b0, f[8] | f[9], f[7:2]};
  endfunction : exp_st

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, rd, err);
    `CHK(rd, {24'h000000, e});
    `CHK(err, 1'b0);
  endtask : rdchk

  task automatic pulse(input logic [9:0] f, input logic [15:0] c,
                       input logic s);
    flt <= f;
    cellOv <= c;
    stStart <= s;
    @(posedge sys_clk);
    flt <= '0;
    cellOv <= '0;
    stStart <= 1'b0;
    @(posedge sys_clk);
  endtask : pulse

  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    foreach (regs[i]) rdchk(regs[i], STATUS_RESET);
    `CHK(faultPresent, 1'b0);
    // Walking ones first, then random fault patterns
    for (int k = 0; k < 28; k++) begin
      v = (k < 10) ? 10'(1 << k) : 10'($random(seed));
      ov = (k < 16) ? 16'(1 << k) : 16'($random(seed));
      pulse(v, ov, 1'b0);
      rdchk(A_PAR, exp_par(v));
      rdchk(A_ST, exp_st(v));
      rdchk(A_OVH, ov[15:8]);
      rdchk(A_OVL, ov[7:0]);
      `CHK(faultPresent, 1'(|{v, ov}));
      apb(1'b1, A_CLR, 32'hffffffff, rd, err);
      `CHK(err, 1'b0);
      repeat (2) @(posedge sys_clk);
      `CHK(faultPresent, 1'b0);
    end
    // Abort, then a completed run, then start colliding with a fault
    pulse(10'h300, 16'h0000, 1'b0);
    rdchk(A_ST, 8'h40);
    pulse(10'h000, 16'h0000, 1'b1);
    rdchk(A_ST, 8'h00);
    pulse(10'h080, 16'h0000, 1'b1);
    rdchk(A_ST, 8'h20);
    // Refused accesses leave the status untouched
    apb(1'b1, A_ST, 32'h000000ff, rd, err);
    `CHK(err, 1'b1);
    rdchk(A_ST, 8'h20);
    apb(1'b0, 14'h0004, 32'h0, rd, err);
    `CHK(err, 1'b1);
    `CHK(rd, 32'h0);
    // Unaligned read is refused
    apb(1'b0, A_PAR + 14'h0001, 32'h0, rd, err);
    `CHK(err, 1'b1);
    `CHK(rd, 32'h0);
    apb(1'b0, A_CLR, 32'h0, rd, err);
    `CHK(err, 1'b0);
    `CHK(rd, 32'h0);
    // One clear lane at a time leaves the other registers set
    for (int j = 0; j < 4; j++) begin
      pulse(10'h3ff, 16'hffff, 1'b0);
      apb(1'b1, A_CLR, 32'hff << (8 * j), rd, err);
      `CHK(err, 1'b0);
      rdchk(A_PAR, (j == 0) ? 8'h00 : 8'h03);
      rdchk(A_ST, (j == 1) ? 8'h00 : 8'h7f);
      rdchk(A_OVL, (j == 2) ? 8'h00 : 8'hff);
      rdchk(A_OVH, (j == 3) ? 8'h00 : 8'hff);
    end
    report_and_stop();
  end
endmodule : tb_top
